// >>> verilog/ibs_pkg.sv
package ibs_pkg;
  localparam int TAG_W = 4;
  localparam int NTAG = 16;
  localparam int DATA_W = 32;
  localparam int MUL_LAT = 2;
  localparam logic [1:0] KIND_ALU = 2'h0;
  localparam logic [1:0] KIND_RESTRICTED = 2'h1;
  localparam logic [1:0] KIND_SHIFT = 2'h2;
  localparam logic [1:0] KIND_MUL = 2'h3;
  localparam logic [1:0] DEC_SHORT2 = 2'h0;
  localparam logic [1:0] DEC_LONG = 2'h1;
  localparam logic [1:0] DEC_VECTOR = 2'h2;
  localparam logic [NTAG-1:0] READY_RESET = 16'hFFFF;
  typedef enum logic [1:0] {
    IBS_IDLE = 2'b00,
    IBS_WAIT = 2'b01,
    IBS_EXEC = 2'b10,
    IBS_MUL2 = 2'b11
  } ibs_slot_type;
endpackage

// >>> verilog/ibs_scheduler.sv
`timescale 1ns/1ps
module ibs_scheduler
  import ibs_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic sys_rst_in, // synchronous reset
  input wire logic [1:0] dec_type_in, // decode kind of this cycle
  input wire logic [1:0] dec_valid_in, // per decoder slot valid
  input wire logic [1:0] dec_kind0_in, // slot 0 operation kind
  input wire logic [1:0] dec_kind1_in, // slot 1 operation kind
  input wire logic [TAG_W-1:0] dec_dst0_in, // slot 0 result tag
  input wire logic [TAG_W-1:0] dec_dst1_in, // slot 1 result tag
  input wire logic [TAG_W-1:0] dec_src0_in, // slot 0 source tag
  input wire logic [TAG_W-1:0] dec_src1_in, // slot 1 source tag
  input wire logic ld_valid_in, // load op (integer or packed)
  input wire logic [TAG_W-1:0] ld_src_in, // load address source tag
  input wire logic [TAG_W-1:0] ld_dst_in, // load result tag
  input wire logic ld_memdep_in, // load aliases pending store
  input wire logic st_valid_in, // store op
  input wire logic [TAG_W-1:0] st_data_in, // store data source tag
  input wire logic st_lea_in, // store unit computes address result
  input wire logic [TAG_W-1:0] st_dst_in, // address result tag
  input wire logic [DATA_W-1:0] rx_res_in, // unit X result value
  input wire logic [DATA_W-1:0] ry_res_in, // unit Y result value
  output logic dec_accept_out, // decode group taken
  output logic [1:0] issue_x_out, // unit X issue, bit1 = bump
  output logic [1:0] issue_y_out, // unit Y issue, bit1 = bump
  output logic [NTAG-1:0] ready_out, // result ready vector
  output logic ld_done_out, // load completes
  output logic ld_fwd_out, // load data forwarded from store queue
  output logic st_done_out, // store completes
  output logic [DATA_W-1:0] sq_data_out // data written to new store queue entry
);
  // two register slots; slot 0 always older
  ibs_slot_type st [2];
  ibs_slot_type next_st [2];
  logic [1:0] kind [2];
  logic [1:0] next_kind [2];
  logic [TAG_W-1:0] src [2];
  logic [TAG_W-1:0] next_src [2];
  logic [TAG_W-1:0] dst [2];
  logic [TAG_W-1:0] next_dst [2];
  logic unit [2];
  logic next_unit [2];
  logic mulhold, next_mulhold;
  logic [NTAG-1:0] next_ready;
  logic ldw, next_ldw;
  logic [TAG_W-1:0] lsrc, next_lsrc, ldst, next_ldst;
  logic ldmem, next_ldmem;
  logic stw, next_stw;
  logic [TAG_W-1:0] sdat, next_sdat;
  logic next_accept, next_lddone, next_fwd, next_stdone;
  logic [1:0] next_ix, next_iy;
  logic [DATA_W-1:0] next_sq;
  logic xbusy, ybusy, ok;
  logic cand [2];

  always_comb begin
    next_st = st;
    next_kind = kind;
    next_src = src;
    next_dst = dst;
    next_unit = unit;
    next_ready = ready_out;
    next_mulhold = 1'b0;
    next_ix = 2'h0;
    next_iy = 2'h0;
    next_ldw = ldw;
    next_lsrc = lsrc;
    next_ldst = ldst;
    next_ldmem = ldmem;
    next_stw = stw;
    next_sdat = sdat;
    next_lddone = 1'b0;
    next_fwd = 1'b0;
    next_stdone = 1'b0;
    next_sq = sq_data_out;
    next_accept = 1'b0;
    xbusy = 1'b0;
    ybusy = 1'b0;
    ok = 1'b0;
    cand[0] = 1'b0;
    cand[1] = 1'b0;
    // retire executing slots; multiply stays a second stage
    for (int i = 0; i < 2; i++) begin
      if (st[i] == IBS_EXEC) begin
        if (kind[i] == KIND_MUL) begin
          next_st[i] = IBS_MUL2;
        end else begin
          next_ready[dst[i]] = 1'b1;
          next_st[i] = IBS_IDLE;
        end
      end else if (st[i] == IBS_MUL2) begin
        if (mulhold && i == 1) begin
          next_st[i] = IBS_MUL2;
        end else begin
          next_ready[dst[i]] = 1'b1;
          next_st[i] = IBS_IDLE;
        end
      end
    end
    // select ready waiting slots, slot 0 first
    for (int i = 0; i < 2; i++) begin
      // bypass a result retiring this cycle
      cand[i] = (st[i] == IBS_WAIT) && next_ready[src[i]];
    end
    for (int i = 0; i < 2; i++) begin
      if (cand[i]) begin
        // first unit only for shift and restricted
        if (kind[i] == KIND_SHIFT || kind[i] == KIND_RESTRICTED || !xbusy) begin
          if (!xbusy) begin
            xbusy = 1'b1;
            next_unit[i] = 1'b0;
            next_st[i] = IBS_EXEC;
            next_ix = 2'h1;
          end
        end else if (!ybusy) begin
          ybusy = 1'b1;
          next_unit[i] = 1'b1;
          next_st[i] = IBS_EXEC;
          next_iy = 2'h1;
        end
      end else if (st[i] == IBS_WAIT) begin
        if (next_unit[i]) next_iy = 2'h2;
        else next_ix = 2'h2;
        next_unit[i] = 1'b0;
      end
    end
    // both units start a multiply together
    if (st[0] == IBS_EXEC && st[1] == IBS_EXEC && kind[0] == KIND_MUL
        && kind[1] == KIND_MUL) begin
      next_mulhold = 1'b1;
    end
    // accept a decode group only into free slots
    ok = (next_st[0] == IBS_IDLE) && (next_st[1] == IBS_IDLE) && !next_ldw && !next_stw;
    if (ok && dec_valid_in != 2'h0) begin
      next_accept = 1'b1;
      for (int i = 0; i < 2; i++) begin
        if (dec_valid_in[i] && (i == 0 || dec_type_in == DEC_SHORT2)) begin
          next_st[i] = IBS_WAIT;
          next_kind[i] = (i == 0) ? dec_kind0_in : dec_kind1_in;
          next_src[i] = (i == 0) ? dec_src0_in : dec_src1_in;
          next_dst[i] = (i == 0) ? dec_dst0_in : dec_dst1_in;
          next_ready[next_dst[i]] = 1'b0;
        end
      end
      // long add expands into load, register and store at once
      // packed loads take the same load path
      if (ld_valid_in) begin
        next_ldw = 1'b1;
        next_lsrc = ld_src_in;
        next_ldst = ld_dst_in;
        next_ldmem = ld_memdep_in && st_valid_in;
        next_ready[ld_dst_in] = 1'b0;
      end
      // store issues without waiting for data
      if (st_valid_in) begin
        next_stw = 1'b1;
        next_sdat = st_data_in;
        if (st_lea_in) next_ready[st_dst_in] = 1'b1;
      end
    end
    // load waits for its operand in order
    if (ldw && ready_out[lsrc] && !(ldmem && stw)) begin
      next_ldw = 1'b0;
      next_lddone = 1'b1;
      // forwarded from store queue after store done
      next_fwd = ldmem;
      next_ready[ldst] = 1'b1;
    end
    // store completes once data is ready
    if (stw && ready_out[sdat]) begin
      next_stw = 1'b0;
      next_stdone = 1'b1;
      // result straight into store queue entry
      // take the value from the unit that produced the data tag
      next_sq = rx_res_in;
      for (int i = 0; i < 2; i++) begin
        if (dst[i] == sdat && unit[i]) next_sq = ry_res_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 2; i++) begin
        st[i] <= IBS_IDLE;
        kind[i] <= KIND_ALU;
        src[i] <= '0;
        dst[i] <= '0;
        unit[i] <= 1'b0;
      end
      mulhold <= 1'b0;
      ready_out <= READY_RESET;
      ldw <= 1'b0;
      lsrc <= '0;
      ldst <= '0;
      ldmem <= 1'b0;
      stw <= 1'b0;
      sdat <= '0;
      dec_accept_out <= 1'b0;
      issue_x_out <= 2'h0;
      issue_y_out <= 2'h0;
      ld_done_out <= 1'b0;
      ld_fwd_out <= 1'b0;
      st_done_out <= 1'b0;
      sq_data_out <= '0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      src <= next_src;
      dst <= next_dst;
      unit <= next_unit;
      mulhold <= next_mulhold;
      ready_out <= next_ready;
      ldw <= next_ldw;
      lsrc <= next_lsrc;
      ldst <= next_ldst;
      ldmem <= next_ldmem;
      stw <= next_stw;
      sdat <= next_sdat;
      dec_accept_out <= next_accept;
      issue_x_out <= next_ix;
      issue_y_out <= next_iy;
      ld_done_out <= next_lddone;
      ld_fwd_out <= next_fwd;
      st_done_out <= next_stdone;
      sq_data_out <= next_sq;
    end
  end

  // no unit shows issue and bump together (code 3)
  AST_ONE_PER_UNIT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !(issue_x_out == 2'h3 || issue_y_out == 2'h3)) else $error("bad issue code");
  AST_FWD_DONE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ld_fwd_out |-> ld_done_out) else $error("forward without load done");
  // held multiply finishes a cycle later
  AST_MUL_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    mulhold |-> st[1] == IBS_MUL2) else $error("held multiply lost");
  // multiply not ready right after issue
  AST_MUL_LAT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st[0] == IBS_EXEC && kind[0] == KIND_MUL) |=> st[0] == IBS_MUL2)
    else $error("multiply skipped stage");
  AST_ONE_CYCLE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st[0] == IBS_EXEC && kind[0] != KIND_MUL) |=> ready_out[$past(dst[0])])
    else $error("one-cycle result late");
  AST_SHIFT_X: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st[0] == IBS_EXEC && kind[0] == KIND_SHIFT) |-> !unit[0])
    else $error("shift in second unit");
  // store done only when data ready
  AST_ST_DATA: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (stw && !ready_out[sdat]) |=> !st_done_out) else $error("store done early");
  // no issue while source not ready
  AST_WAIT_SRC: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st[0] == IBS_WAIT && !ready_out[src[0]]
     && !(st[1] == IBS_EXEC && kind[1] != KIND_MUL && dst[1] == src[0])
     && !(st[1] == IBS_MUL2 && !mulhold && dst[1] == src[0])) |=> st[0] != IBS_EXEC)
    else $error("issued before source ready");
endmodule

// >>> tb/ibs_exec_model.sv
`timescale 1ns/1ps
// execution unit side: presents unit result values one edge after the bench sets them
module ibs_exec_model
  import ibs_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic [DATA_W-1:0] x_val_in, // value unit X will produce
  input wire logic [DATA_W-1:0] y_val_in, // value unit Y will produce
  output logic [DATA_W-1:0] rx_res_out, // unit X result
  output logic [DATA_W-1:0] ry_res_out // unit Y result
);
  always_ff @(posedge core_clk_in) begin
    rx_res_out <= x_val_in;
    ry_res_out <= y_val_in;
  end
endmodule

// >>> tb/issue_bypass_scheduler_tb_top.sv
`timescale 1ns/1ps
module issue_bypass_scheduler_tb_top;
  import ibs_pkg::*;
  logic core_clk_in, sys_rst_in, ld_valid, ld_memdep, st_valid, st_lea;
  logic dec_accept, ld_done, ld_fwd, st_done;
  logic [1:0] dec_type, dec_valid, kind0, kind1, iss_x, iss_y;
  logic [TAG_W-1:0] dst0, dst1, src0, src1, ld_src, ld_dst, st_data, st_dst;
  logic [DATA_W-1:0] x_val, y_val, rx_res, ry_res, sq_data;
  logic [NTAG-1:0] ready;
  int fail_count, compares;
  logic [3:0] iss_q[$];
  logic [DATA_W-1:0] sq_q[$];
  logic ld_q[$];

  ibs_exec_model ibs_exec_model_i (.core_clk_in(core_clk_in), .x_val_in(x_val),
    .y_val_in(y_val), .rx_res_out(rx_res), .ry_res_out(ry_res));
  ibs_scheduler ibs_scheduler_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .dec_type_in(dec_type), .dec_valid_in(dec_valid), .dec_kind0_in(kind0),
    .dec_kind1_in(kind1), .dec_dst0_in(dst0), .dec_dst1_in(dst1), .dec_src0_in(src0),
    .dec_src1_in(src1), .ld_valid_in(ld_valid), .ld_src_in(ld_src), .ld_dst_in(ld_dst),
    .ld_memdep_in(ld_memdep), .st_valid_in(st_valid), .st_data_in(st_data),
    .st_lea_in(st_lea), .st_dst_in(st_dst), .rx_res_in(rx_res), .ry_res_in(ry_res),
    .dec_accept_out(dec_accept), .issue_x_out(iss_x), .issue_y_out(iss_y),
    .ready_out(ready), .ld_done_out(ld_done), .ld_fwd_out(ld_fwd),
    .st_done_out(st_done), .sq_data_out(sq_data));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // hold the group until it is accepted, then withdraw it
  task automatic send_group(input logic [1:0] ty, input logic [1:0] v, input logic [1:0] k0,
                            input logic [1:0] k1);
    int n;
    @(posedge core_clk_in);
    dec_type <= ty;
    dec_valid <= v;
    kind0 <= k0;
    kind1 <= k1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk_in);
      #1;
      if (dec_accept === 1'b1) break;
    end
    if (n == 20) check_bit("accept timeout", 1'b1, 1'b0);
    @(posedge core_clk_in);
    dec_valid <= 2'h0;
    ld_valid <= 1'b0;
    st_valid <= 1'b0;
    repeat (8) @(posedge core_clk_in);
  endtask

  // monitor: each result takes the oldest note of its kind
  always @(negedge core_clk_in) begin
    if (!sys_rst_in) begin
      if (iss_x !== 2'h0 || iss_y !== 2'h0) begin
        if (iss_q.size() == 0) check_vec("unexpected issue", 32'h0, {iss_x, iss_y});
        else check_vec("issue x,y", {28'h0, iss_q.pop_front()}, {28'h0, iss_x, iss_y});
      end
      if (st_done === 1'b1) begin
        if (sq_q.size() == 0) check_bit("unexpected store done", 1'b0, 1'b1);
        else check_vec("store queue data", sq_q.pop_front(), sq_data);
      end
      if (ld_done === 1'b1) begin
        if (ld_q.size() == 0) check_bit("unexpected load done", 1'b0, 1'b1);
        else check_bit("load forwarded", ld_q.pop_front(), ld_fwd);
      end
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    {dec_type, dec_valid, kind0, kind1} = 8'h00;
    {dst0, dst1, src0, src1, ld_src, ld_dst, st_data, st_dst} = 32'h00000000;
    {ld_valid, ld_memdep, st_valid, st_lea} = 4'h0;
    x_val = $urandom(32'h622e8f76);
    y_val = $urandom();
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge core_clk_in);
    check_vec("ready after reset", {16'h0, READY_RESET}, {16'h0, ready});
    @(posedge core_clk_in);
    src0 <= 4'h0;
    src1 <= 4'h1;
    dst0 <= 4'h2;
    dst1 <= 4'h3;
    iss_q.push_back(4'h5);
    send_group(DEC_SHORT2, 2'h3, KIND_ALU, KIND_ALU);
    iss_q.push_back(4'h4);
    send_group(DEC_SHORT2, 2'h1, KIND_SHIFT, KIND_ALU);
    iss_q.push_back(4'h4);
    send_group(DEC_SHORT2, 2'h1, KIND_RESTRICTED, KIND_ALU);
    // slot 1 depends on slot 0: bumped from Y, then reissued to X behind it
    @(posedge core_clk_in);
    src0 <= 4'h0;
    dst0 <= 4'h8;
    src1 <= 4'h8;
    dst1 <= 4'h9;
    iss_q.push_back(4'h6);
    iss_q.push_back(4'h4);
    send_group(DEC_SHORT2, 2'h3, KIND_ALU, KIND_ALU);
    // two multiplies start together
    @(posedge core_clk_in);
    src1 <= 4'h1;
    dst0 <= 4'hA;
    dst1 <= 4'hB;
    iss_q.push_back(4'h5);
    send_group(DEC_SHORT2, 2'h3, KIND_MUL, KIND_MUL);
    // long op: alu result feeds a new store entry, aliasing load forwards
    @(posedge core_clk_in);
    src0 <= 4'h2;
    dst0 <= 4'h6;
    ld_valid <= 1'b1;
    ld_src <= 4'h1;
    ld_dst <= 4'h5;
    ld_memdep <= 1'b1;
    st_valid <= 1'b1;
    st_data <= 4'h6;
    st_dst <= 4'h7;
    iss_q.push_back(4'h4);
    sq_q.push_back(x_val);
    ld_q.push_back(1'b1);
    send_group(DEC_LONG, 2'h1, KIND_ALU, KIND_ALU);
    repeat (10) @(posedge core_clk_in);
    check_vec("notes left", 32'h0, iss_q.size() + sq_q.size() + ld_q.size());
    print_verdict();
  end
endmodule
